// ---- verilog/gtm_pkg.sv ----
// Package for the guard timer: register map, control fields, divider ratios.
// Assumes one system clock domain and the CPU register port of the host MCU.
// Summary of operation
// - Timer clock is oscillator clock divided by 4096, 1024 or 128.
// - Eight-bit up-counter at address FDH, readable, never writable.
// - Reset clears control to 00H: watchdog on, divide-by-4096 selected.
// - Watchdog reset disabled only while control bits 7..4 equal 1010B.
// - Writing one to control bit 1 clears the counter.
// - Writing one to control bit 0 clears the divider stages.
// - Counter overflow out of bit 7 resets the chip when watchdog enabled.
// - In Stop mode, reset or external interrupt starts the oscillator.
// - Stop release counts at divide-by-4096 for reset, else selected rate.
// - Counter bit 4 overflow ends stabilization and re-enables the CPU clock.
// - After reset, timer clock is oscillator clock divided by 4096.
`default_nettype none
package gtm_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] GTM_CTRL_ADDR   = 8'hD3;
   localparam logic [7:0] GTM_COUNT_ADDR  = 8'hFD;
   localparam logic [7:0] GTM_CTRL_RESET  = 8'h00;
   localparam logic [7:0] GTM_COUNT_RESET = 8'h00;
   // ****************************************
   // Control fields
   // ****************************************
   localparam int         GTM_WD_HI      = 7;
   localparam int         GTM_WD_LO      = 4;
   localparam logic [3:0] GTM_WD_DISABLE = 4'hA;
   localparam int         GTM_SEL_HI     = 3;
   localparam int         GTM_SEL_LO     = 2;
   localparam int         GTM_CNT_CLR    = 1;
   localparam int         GTM_DIV_CLR    = 0;
   localparam int         GTM_STAB_BIT   = 4;
   // Divider select codes, taps are bit index of a 4096 prescaler
   localparam logic [1:0] GTM_SEL_4096 = 2'h0;
   localparam logic [1:0] GTM_SEL_1024 = 2'h1;
   localparam logic [1:0] GTM_SEL_128  = 2'h2;
   localparam int         GTM_DIV_W    = 12;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } gtm_bus_t;

   typedef enum logic [2:0] {
      GTM_RUN  = 3'b001,
      GTM_STOP = 3'b010,
      GTM_STAB = 3'b100
   } gtm_state_t;
endpackage
`default_nettype wire

// ---- verilog/gtm_guard_timer.sv ----
// Guard timer: watchdog and oscillator stabilization counter.
// Assumes clk is the oscillator clock fxx and bus signals are synchronous.
`timescale 1ns/1ps
`default_nettype none
module gtm_guard_timer #(
   // Width of the slow prescaler tap; the default gives the divide-by-4096 rate
   parameter int TAP_SLOW_W = gtm_pkg::GTM_DIV_W
) (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire gtm_pkg::gtm_bus_t bus,
   output logic [7:0]             rdata,
   input  wire logic              stop_req,
   input  wire logic              ext_irq,
   output logic                   osc_en,
   output logic                   cpu_clk_en,
   output logic                   stab_done,
   output logic                   wdt_reset
);
   // ****************************************
   // Register access
   // ****************************************
   logic [7:0]              ctrl_q;
   logic [7:0]              count_q;
   logic [gtm_pkg::GTM_DIV_W-1:0] div_q;
   gtm_pkg::gtm_state_t     state_q;
   logic                    ext_s1_q;
   logic                    ext_s2_q;
   logic                    from_reset_q;
   logic                    wr_ctrl;
   logic                    tick;
   logic [1:0]              sel;
   logic                    ovf7;
   logic                    wd_on;

   assign wr_ctrl = bus.wr && (bus.addr == gtm_pkg::GTM_CTRL_ADDR);

   // Clear strobe bits are never stored so they read back zero
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         ctrl_q <= gtm_pkg::GTM_CTRL_RESET;
      else if (wr_ctrl)
         ctrl_q <= {bus.wdata[7:2], 2'b00};

   always_comb
   begin
      rdata = 8'h00;
      if (bus.rd && bus.addr == gtm_pkg::GTM_CTRL_ADDR)
         rdata = ctrl_q;
      else if (bus.rd && bus.addr == gtm_pkg::GTM_COUNT_ADDR)
         rdata = count_q;
   end

   // ****************************************
   // Prescaler
   // ****************************************
   // Reset stabilization always uses 4096 regardless of the select field
   assign sel = (state_q == gtm_pkg::GTM_STAB && from_reset_q)
                ? gtm_pkg::GTM_SEL_4096 : ctrl_q[gtm_pkg::GTM_SEL_HI:gtm_pkg::GTM_SEL_LO];

   function automatic logic tap_done(input logic [11:0] d, input logic [1:0] s);
      case (s)
         gtm_pkg::GTM_SEL_1024: tap_done = &d[9:0];
         gtm_pkg::GTM_SEL_128:  tap_done = &d[6:0];
         default:               tap_done = &d[TAP_SLOW_W-1:0];
      endcase
   endfunction

   assign tick = tap_done(div_q, sel) && (state_q != gtm_pkg::GTM_STOP);

   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         div_q <= '0;
      else if (wr_ctrl && bus.wdata[gtm_pkg::GTM_DIV_CLR])
         div_q <= '0;
      else if (state_q != gtm_pkg::GTM_STOP)
         div_q <= div_q + 12'h001;

   // ****************************************
   // Counter and watchdog
   // ****************************************
   assign ovf7  = tick && (count_q == 8'hFF);
   assign wd_on = ctrl_q[gtm_pkg::GTM_WD_HI:gtm_pkg::GTM_WD_LO] != gtm_pkg::GTM_WD_DISABLE;

   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         count_q <= gtm_pkg::GTM_COUNT_RESET;
      else if (wr_ctrl && bus.wdata[gtm_pkg::GTM_CNT_CLR])
         count_q <= 8'h00;
      else if (state_q == gtm_pkg::GTM_STOP)
         count_q <= 8'h00;
      else if (tick)
         count_q <= count_q + 8'h01;

   // Registered so the reset pulse is glitch free
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         wdt_reset <= 1'b0;
      else
         wdt_reset <= ovf7 && wd_on && (state_q == gtm_pkg::GTM_RUN);

   // ****************************************
   // Stop and stabilization
   // ****************************************
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
      end
      else
      begin
         ext_s1_q <= ext_irq;
         ext_s2_q <= ext_s1_q;
      end

   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         state_q      <= gtm_pkg::GTM_STAB;
         from_reset_q <= 1'b1;
      end
      else
         case (state_q)
            gtm_pkg::GTM_RUN:
               if (stop_req)
                  state_q <= gtm_pkg::GTM_STOP;
            gtm_pkg::GTM_STOP:
               if (ext_s2_q)
               begin
                  state_q      <= gtm_pkg::GTM_STAB;
                  from_reset_q <= 1'b0;
               end
            gtm_pkg::GTM_STAB:
               if (tick && (&count_q[gtm_pkg::GTM_STAB_BIT:0]))
               begin
                  state_q      <= gtm_pkg::GTM_RUN;
                  from_reset_q <= 1'b0;
               end
            default:
               state_q <= gtm_pkg::GTM_RUN;
         endcase

   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         stab_done <= 1'b0;
      else
         stab_done <= (state_q == gtm_pkg::GTM_STAB)
                      && tick && (&count_q[gtm_pkg::GTM_STAB_BIT:0]);

   assign osc_en     = (state_q != gtm_pkg::GTM_STOP);
   assign cpu_clk_en = (state_q == gtm_pkg::GTM_RUN);
endmodule
`default_nettype wire

// ---- bench/gtm_guard_timer_asserts.sv ----
// Checker for the guard timer, bound to its top module.
// Assumes one clk domain and rst_b active low.
`timescale 1ns/1ps
`default_nettype none
module gtm_guard_timer_chk (
   input wire logic              clk,
   input wire logic              rst_b,
   input wire gtm_pkg::gtm_bus_t bus,
   input wire logic [7:0]        rdata,
   input wire logic              stop_req,
   input wire logic              ext_irq,
   input wire logic              osc_en,
   input wire logic              cpu_clk_en,
   input wire logic              stab_done,
   input wire logic              wdt_reset
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire is_c = bus.addr == gtm_pkg::GTM_CTRL_ADDR;
   wire is_n = bus.addr == gtm_pkg::GTM_COUNT_ADDR;
   // ****************************************
   // Properties
   // ****************************************
   property p_rd; bus.rd && is_c |-> rdata[1:0] == 2'h0; endproperty
   property p_unm; bus.rd && !is_c && !is_n |-> rdata == 8'h00; endproperty
   // Slack of three cycles covers a tick already in flight
   property p_off; bus.wr && is_c && bus.wdata[7:4] == 4'hA |-> ##3 !wdt_reset [*8]; endproperty
   property p_wdp; wdt_reset |=> !wdt_reset; endproperty
   property p_wdr; wdt_reset |-> $past(cpu_clk_en); endproperty
   property p_stab; stab_done |-> ##[0:1] cpu_clk_en; endproperty
   property p_stop; stop_req && cpu_clk_en |-> ##[1:2] !osc_en; endproperty
   property p_clr; bus.wr && is_c && bus.wdata[1] ##[1:2] bus.rd && is_n |-> rdata <= 8'h01;
   endproperty
   a_rd: assert property (p_rd) else $error("clear bits read back set");
   a_unm: assert property (p_unm) else $error("unmapped read not zero");
   a_off: assert property (p_off) else $error("reset while disabled");
   a_wdp: assert property (p_wdp) else $error("reset pulse too long");
   a_wdr: assert property (p_wdr) else $error("reset outside run");
   a_stab: assert property (p_stab) else $error("cpu clock not back");
   a_stop: assert property (p_stop) else $error("oscillator kept in stop");
   a_clr: assert property (p_clr) else $error("counter not cleared");
   c_stab: cover property (stab_done);
   c_wd: cover property (wdt_reset);
   c_stop: cover property (stop_req && cpu_clk_en);
endmodule
bind gtm_guard_timer gtm_guard_timer_chk u_chk (.clk(clk), .rst_b(rst_b), .bus(bus),
   .rdata(rdata), .stop_req(stop_req), .ext_irq(ext_irq), .osc_en(osc_en),
   .cpu_clk_en(cpu_clk_en), .stab_done(stab_done), .wdt_reset(wdt_reset));
`default_nettype wire

// ---- bench/test_watchdog_stabilization_timer.sv ----
// Bench for the guard timer: bus calls with expected values.
// Assumes the checker file is compiled beside it; slow tap shortened, about 90k cycles.
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_stabilization_timer;
   logic clk = 0, rst_b = 0, stop_req = 0, ext_irq = 0;
   logic osc_en, cpu_clk_en, stab_done, wdt_reset;
   logic [7:0] rdata;
   gtm_pkg::gtm_bus_t bus = '0;
   int mismatches = 0, n_compared = 0, n;
   // Slow rate cut to 512 so the reset interval fits the cycle budget
   localparam int SLOW_W = 9;
   localparam int SLOW   = 2**SLOW_W;
   initial forever #2.5 clk = ~clk;
   gtm_guard_timer #(.TAP_SLOW_W(SLOW_W)) u_dut (.clk(clk), .rst_b(rst_b), .bus(bus),
      .rdata(rdata),
      .stop_req(stop_req), .ext_irq(ext_irq), .osc_en(osc_en), .cpu_clk_en(cpu_clk_en),
      .stab_done(stab_done), .wdt_reset(wdt_reset));
   task print_verdict;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [7:0] g, e);
      n_compared++;
      if (g !== e)
      begin
         mismatches++;
         $display("FAIL %0t got %h want %h", $time, g, e);
      end
   endtask
   // Tasks start and end on a falling edge
   task wr(input logic [7:0] a, d);
      bus.wr = 1; bus.addr = a; bus.wdata = d;
      @(negedge clk) bus.wr = 0;
      @(negedge clk);
   endtask
   task rd(input logic [7:0] a, e);
      bus.rd = 1; bus.addr = a;
      #1 chk(rdata, e);
      @(negedge clk) bus.rd = 0;
      @(negedge clk);
   endtask
   // Pulses stand a full cycle, so sampling mid-cycle is safe
   task wt(input int k, lim);
      n = 0;
      while ((k ? wdt_reset : stab_done) !== 1'b1 && n < lim)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= lim)
      begin
         mismatches++;
         $display("FAIL %0t timeout", $time);
         print_verdict;
      end
   endtask
   initial
   begin
      repeat (3) @(negedge clk);
      rst_b = 1;
      rd(8'hD3, 8'h00);
      chk({6'h0, osc_en, cpu_clk_en}, 8'h02);
      wt(0, 20000);
      chk(8'(n > 31*SLOW && n <= 32*SLOW), 8'h01);
      chk({7'h0, cpu_clk_en}, 8'h01);
      $display("test reset done");
      wr(8'hD3, 8'h0B);
      rd(8'hFD, 8'h00);
      rd(8'hD3, 8'h08);
      wr(8'hFD, 8'h55);
      rd(8'hFD, 8'h00);
      rd(8'h10, 8'h00);
      wt(1, 40000);
      chk(8'(n > 255*128 && n <= 256*128), 8'h01);
      $display("test watchdog done");
      stop_req = 1;
      @(negedge clk) stop_req = 0;
      @(negedge clk);
      chk({6'h0, osc_en, cpu_clk_en}, 8'h00);
      rd(8'hFD, 8'h00);
      ext_irq = 1;
      repeat (3) @(negedge clk);
      ext_irq = 0;
      chk({7'h0, osc_en}, 8'h01);
      wt(0, 5000);
      chk(8'(n <= 32*128), 8'h01);
      @(negedge clk);
      chk({7'h0, cpu_clk_en}, 8'h01);
      wr(8'hD3, 8'hA8);
      rd(8'hD3, 8'hA8);
      // Longer than one full counter wrap at divide-by-128, so an overflow occurs
      n = 0;
      repeat (33000)
      begin
         @(negedge clk);
         if (wdt_reset !== 1'b0)
            n++;
      end
      chk(8'(n), 8'h00);
      $display("test stop done");
      print_verdict;
   end
endmodule
`default_nettype wire
